// ### chan_ctl_consts.vh
// Constants for the per-channel enable and loop control block.
// Assumes inclusion by bare name from the design files.
`ifndef CHAN_CTL_CONSTS_VH
`define CHAN_CTL_CONSTS_VH
`define CH_NUM_CHANNELS   4
`define CH_QPTR_WIDTH     2
`define CH_STATUS_WIDTH   8
`define CH_BUF_WIDTH      16
`define CH_EN_RESET       1'b0
`define CH_LOOP_RESET     1'b0
`define CH_ST_DISABLED    2'h0
`define CH_ST_ACTIVE      2'h1
`define CH_ST_LOOP        2'h2
`endif

// ### chan_slice.v
// One channel: enable/loop state machine, queue pointers, status, buffer and bus routing.
// Assumes synchronous inputs on mclk_i; the host port decoder supplies settings and strobes.
`timescale 1ns/1ps
`include "chan_ctl_consts.vh"
module chan_slice #(
  parameter QW = `CH_QPTR_WIDTH,
  parameter SW = `CH_STATUS_WIDTH,
  parameter BW = `CH_BUF_WIDTH
) (
  input  wire          mclk_i,
  input  wire          resetn_i,
  input  wire          en_wr_i,
  input  wire          en_val_i,
  input  wire          loop_wr_i,
  input  wire          loop_val_i,
  input  wire          tx_push_i,
  input  wire          rx_pop_i,
  input  wire          xfer_start_i,
  input  wire          xfer_done_i,
  input  wire [BW-1:0] buf_wdata_i,
  input  wire          buf_wr_i,
  input  wire [SW-1:0] status_set_i,
  input  wire          tx_bit_i,
  input  wire          bus_rx_i,
  output reg           drive_permit_o,
  output reg           loop_o,
  output reg           busy_o,
  output reg  [QW-1:0] tx_ptr_o,
  output reg  [QW-1:0] rx_ptr_o,
  output reg  [SW-1:0] status_o,
  output reg  [BW-1:0] buf_o,
  output reg           bus_tx_o,
  output reg           bus_oe_o,
  output reg           rx_bit_o
);
  localparam [1:0] ST_DIS  = `CH_ST_DISABLED;
  localparam [1:0] ST_ACT  = `CH_ST_ACTIVE;
  localparam [1:0] ST_LOOP = `CH_ST_LOOP;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg        clear_all;
  wire       en_nxt;
  wire       loop_nxt;

  assign en_nxt   = en_wr_i ? en_val_i : drive_permit_o;
  assign loop_nxt = loop_wr_i ? loop_val_i : loop_o;

  always @* begin
    state_nxt = state_r;
    clear_all = 1'b0;
    case (state_r)
      ST_DIS: begin
        if (loop_nxt) begin
          state_nxt = ST_LOOP;
          clear_all = 1'b1;
        end else if (en_nxt) begin
          state_nxt = ST_ACT;
        end
      end
      ST_ACT: begin
        if (loop_nxt) begin
          state_nxt = ST_LOOP;
          clear_all = 1'b1;
        end else if (!en_nxt) begin
          state_nxt = ST_DIS;
          clear_all = 1'b1;
        end
      end
      ST_LOOP: begin
        if (!loop_nxt) begin
          state_nxt = ST_DIS;
          clear_all = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_DIS;
        clear_all = 1'b1;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_r        <= ST_DIS;
      drive_permit_o <= `CH_EN_RESET;
      loop_o         <= `CH_LOOP_RESET;
      busy_o         <= 1'b0;
      tx_ptr_o       <= {QW{1'b0}};
      rx_ptr_o       <= {QW{1'b0}};
      status_o       <= {SW{1'b0}};
      buf_o          <= {BW{1'b0}};
    end else begin
      state_r <= state_nxt;
      loop_o  <= loop_nxt;
      // Entering loop drops the enable; leaving loop also leaves it at its reset value
      drive_permit_o <= (state_nxt == ST_ACT) ? 1'b1 : `CH_EN_RESET;
      if (clear_all) begin
        busy_o   <= 1'b0;
        tx_ptr_o <= {QW{1'b0}};
        rx_ptr_o <= {QW{1'b0}};
        status_o <= {SW{1'b0}};
        buf_o    <= {BW{1'b0}};
      end else if (state_r != ST_DIS) begin
        // Same wrap-around counters in loop and normal mode
        if (tx_push_i)
          tx_ptr_o <= tx_ptr_o + {{(QW-1){1'b0}}, 1'b1};
        if (rx_pop_i)
          rx_ptr_o <= rx_ptr_o + {{(QW-1){1'b0}}, 1'b1};
        if (xfer_start_i)
          busy_o <= 1'b1;
        else if (xfer_done_i)
          busy_o <= 1'b0;
        status_o <= status_o | status_set_i;
        if (buf_wr_i)
          buf_o <= buf_wdata_i;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      bus_tx_o <= 1'b0;
      bus_oe_o <= 1'b0;
      rx_bit_o <= 1'b0;
    end else begin
      // Bus driven only when active; loop isolates the external lines
      bus_oe_o <= (state_nxt == ST_ACT);
      bus_tx_o <= (state_nxt == ST_ACT) ? tx_bit_i : 1'b0;
      rx_bit_o <= (state_nxt == ST_LOOP) ? tx_bit_i :
                  (state_nxt == ST_ACT)  ? bus_rx_i : 1'b0;
    end
  end
endmodule // chan_slice

// ### bus_channel_enable_loopback.v
// Top of the differential_sensor_bus channel enable and loop control, all channels.
// Assumes the host port decoder gives one-cycle write strobes per channel, synchronous.
`timescale 1ns/1ps
`include "chan_ctl_consts.vh"
module bus_channel_enable_loopback #(
  parameter NCH = `CH_NUM_CHANNELS,
  parameter QW  = `CH_QPTR_WIDTH,
  parameter SW  = `CH_STATUS_WIDTH,
  parameter BW  = `CH_BUF_WIDTH
) (
  input  wire              mclk_i,
  input  wire              resetn_i,
  input  wire [NCH-1:0]    en_wr_i,
  input  wire [NCH-1:0]    en_val_i,
  input  wire [NCH-1:0]    loop_wr_i,
  input  wire [NCH-1:0]    loop_val_i,
  input  wire [NCH-1:0]    tx_push_i,
  input  wire [NCH-1:0]    rx_pop_i,
  input  wire [NCH-1:0]    xfer_start_i,
  input  wire [NCH-1:0]    xfer_done_i,
  input  wire [NCH*BW-1:0] buf_wdata_i,
  input  wire [NCH-1:0]    buf_wr_i,
  input  wire [NCH*SW-1:0] status_set_i,
  input  wire [NCH-1:0]    tx_bit_i,
  input  wire [NCH-1:0]    bus_rx_i,
  output wire [NCH-1:0]    channel_drive_permit_bit_o,
  output wire [NCH-1:0]    loop_o,
  output wire [NCH-1:0]    busy_o,
  output wire [NCH*QW-1:0] tx_ptr_o,
  output wire [NCH*QW-1:0] rx_ptr_o,
  output wire [NCH*SW-1:0] status_o,
  output wire [NCH*BW-1:0] buf_o,
  output wire [NCH-1:0]    bus_tx_o,
  output wire [NCH-1:0]    bus_oe_o,
  output wire [NCH-1:0]    rx_bit_o
);
  // Each slice owns all of its state, so one channel's clear cannot reach another
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      chan_slice #(.QW(QW), .SW(SW), .BW(BW)) u_ch (
        .mclk_i         (mclk_i),
        .resetn_i       (resetn_i),
        .en_wr_i        (en_wr_i[g]),
        .en_val_i       (en_val_i[g]),
        .loop_wr_i      (loop_wr_i[g]),
        .loop_val_i     (loop_val_i[g]),
        .tx_push_i      (tx_push_i[g]),
        .rx_pop_i       (rx_pop_i[g]),
        .xfer_start_i   (xfer_start_i[g]),
        .xfer_done_i    (xfer_done_i[g]),
        .buf_wdata_i    (buf_wdata_i[g*BW +: BW]),
        .buf_wr_i       (buf_wr_i[g]),
        .status_set_i   (status_set_i[g*SW +: SW]),
        .tx_bit_i       (tx_bit_i[g]),
        .bus_rx_i       (bus_rx_i[g]),
        .drive_permit_o (channel_drive_permit_bit_o[g]),
        .loop_o         (loop_o[g]),
        .busy_o         (busy_o[g]),
        .tx_ptr_o       (tx_ptr_o[g*QW +: QW]),
        .rx_ptr_o       (rx_ptr_o[g*QW +: QW]),
        .status_o       (status_o[g*SW +: SW]),
        .buf_o          (buf_o[g*BW +: BW]),
        .bus_tx_o       (bus_tx_o[g]),
        .bus_oe_o       (bus_oe_o[g]),
        .rx_bit_o       (rx_bit_o[g])
      );
    end
  endgenerate
endmodule // bus_channel_enable_loopback

// ### bel_props.sv
// Checks channel 0 of the enable and loop control; all slices are copies of it.
// Assumes a bind into the four-channel top module.
`timescale 1ns/1ps
module bel_props (
  input        mclk_i, resetn_i,
  input [3:0]  en_wr_i, en_val_i, loop_wr_i, loop_val_i, tx_push_i, tx_bit_i,
  input [3:0]  channel_drive_permit_bit_o, loop_o, busy_o, bus_oe_o, rx_bit_o, bus_tx_o,
  input [7:0]  tx_ptr_o, rx_ptr_o,
  input [31:0] status_o,
  input [63:0] buf_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire clr = {tx_ptr_o[1:0], rx_ptr_o[1:0], status_o[7:0], buf_o[15:0]} == 28'h0;
  wire pm = channel_drive_permit_bit_o[0];
  oe_off_a: assert property (!pm |-> !bus_oe_o[0] && !bus_tx_o[0]) else $error("drive while off");
  dis_clr_a: assert property ($fell(pm) && !loop_o[0] |-> clr) else $error("stale state");
  stop_xfer_a: assert property (en_wr_i[0] && !en_val_i[0] && !loop_wr_i[0] && !loop_o[0] |=>
    !busy_o[0]) else $error("transfer kept");
  loop_rx_a: assert property ($past(loop_o[0]) && loop_o[0] |->
    rx_bit_o[0] == $past(tx_bit_i[0])) else $error("loop data lost");
  loop_iso_a: assert property (loop_o[0] |-> !bus_oe_o[0] && !pm) else $error("bus in loop");
  loop_in_a: assert property (loop_wr_i[0] && loop_val_i[0] && !loop_o[0] |=>
    loop_o[0] && !pm && clr) else $error("loop entry");
  loop_out_a: assert property (loop_wr_i[0] && !loop_val_i[0] && loop_o[0] |=>
    !loop_o[0] && !pm && clr) else $error("loop exit");
  loop_wrap_a: assert property (loop_o[0] && tx_push_i[0] && !loop_wr_i[0] |=>
    tx_ptr_o[1:0] == $past(tx_ptr_o[1:0]) + 2'h1) else $error("loop step");
  reset_off_a: assert property (disable iff (1'b0) !resetn_i |=>
    channel_drive_permit_bit_o == 4'h0 && bus_oe_o == 4'h0) else $error("on after reset");
  cover property (loop_o[0] && tx_push_i[0]);
  cover property ($fell(busy_o[0]));
  cover property ($fell(loop_o[0]));
endmodule // bel_props

// ### bus_node_model.sv
// Remote nodes on the bus: they hear whatever the master drives.
// Assumes one clock; a released line flips each cycle as nothing holds it.
`timescale 1ns/1ps
module bus_node_model (input mclk_i, input [3:0] tx_i, input [3:0] oe_i,
                       output [3:0] rx_o);
  logic [3:0] last_r = 4'h0;
  assign rx_o = (tx_i & oe_i) | (~last_r & ~oe_i);
  // Released line keeps toggling from a known level, even before the master leaves reset
  always @(posedge mclk_i)
    for (int k = 0; k < 4; k++)
      if (oe_i[k]) last_r[k] <= tx_i[k];
      else last_r[k] <= ~last_r[k];
endmodule // bus_node_model

// ### bus_channel_enable_loopback_bench.sv
// Self-checking bench for the four-channel enable and loop control.
// Assumes the design, bel_props and bus_node_model are compiled first.
`timescale 1ns/1ps
module bus_channel_enable_loopback_bench;
  logic        mclk_i = 1'b0, resetn_i = 1'b0;
  logic [3:0]  en_wr_i = '0, en_val_i = '0, loop_wr_i = '0, loop_val_i = '0, tx_push_i = '0;
  logic [3:0]  rx_pop_i = '0, xfer_start_i = '0, xfer_done_i = '0, buf_wr_i = '0, tx_bit_i = '0;
  logic [63:0] buf_wdata_i = 64'h1234_5678_9abc_def0;
  logic [31:0] status_set_i = '0;
  wire  [3:0]  bus_rx_i, channel_drive_permit_bit_o, loop_o, busy_o, bus_tx_o, bus_oe_o, rx_bit_o;
  wire  [7:0]  tx_ptr_o, rx_ptr_o;
  wire  [31:0] status_o;
  wire  [63:0] buf_o;
  int          err_total = 0, n_tests = 0;
  always #50 mclk_i = ~mclk_i;
  bus_channel_enable_loopback i_dut (.*);
  bus_node_model i_node (.mclk_i, .tx_i(bus_tx_o), .oe_i(bus_oe_o), .rx_o(bus_rx_i));
  task chk(input string n, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) err_total++;
    if (g !== e) $display("CHECK FAILED %s exp %h got %h", n, e, g);
  endtask
  task cyc(input logic [15:0] w);
    @(posedge mclk_i);
    {en_wr_i, en_val_i, loop_wr_i, loop_val_i} <= w;
    @(posedge mclk_i);
    {en_wr_i, loop_wr_i} <= 8'h0;
    #1;
  endtask
  task t_active;
    chk("reset", 16'h0, {8'h0, channel_drive_permit_bit_o, bus_oe_o});
    cyc(16'h3300);
    @(posedge mclk_i);
    {tx_push_i, rx_pop_i, xfer_start_i, buf_wr_i, status_set_i} <= {16'h3333, 32'h0a05};
    @(posedge mclk_i);
    {tx_push_i, rx_pop_i, xfer_start_i, buf_wr_i, status_set_i} <= 48'h0;
    cyc(16'h1200);
    chk("ch0 cleared", 16'h0,
        {2'h0, tx_ptr_o[1:0], rx_ptr_o[1:0], status_o[7:0], busy_o[0], bus_oe_o[0]});
    chk("ch1 kept", {2'h0, 2'h1, 2'h1, 8'h0a, 1'b1, 1'b1},
        {2'h0, tx_ptr_o[3:2], rx_ptr_o[3:2], status_o[15:8], busy_o[1], bus_oe_o[1]});
    chk("ch0 buffer", 16'h0, buf_o[15:0]);
    chk("ch1 buffer", 16'h9abc, buf_o[31:16]);
    @(posedge mclk_i);
    {xfer_done_i, tx_bit_i} <= 8'h22;
    @(posedge mclk_i);
    {xfer_done_i, tx_bit_i} <= 8'h02;
    #1;
    chk("ch1 done", 16'h0, {15'h0, busy_o[1]});
    chk("ch1 drive", 16'h3, {14'h0, bus_tx_o[1], bus_oe_o[1]});
    @(posedge mclk_i);
    #1;
    chk("ch1 receive", 16'h1, {15'h0, rx_bit_o[1]});
    $display("enable test done");
  endtask
  task t_loop;
    cyc(16'h1100);
    cyc(16'h0111);
    chk("loop entry", 16'h2, {14'h0, loop_o[0], bus_oe_o[0]});
    @(posedge mclk_i);
    {tx_push_i, tx_bit_i} <= 8'h1f;
    repeat (5) @(posedge mclk_i);
    {tx_push_i, tx_bit_i} <= 8'h0;
    #1;
    chk("loop wrap", {13'h0, 2'h1, 1'b1}, {13'h0, tx_ptr_o[1:0], rx_bit_o[0]});
    cyc(16'h0110);
    chk("loop exit", 16'h0, {13'h0, loop_o[0], tx_ptr_o[1:0]});
    $display("loop test done");
  endtask
  task t_reset;
    chk("ch1 live", 16'h3, {14'h0, channel_drive_permit_bit_o[1], bus_oe_o[1]});
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    #1;
    chk("reset mid-run", 16'h0, {4'h0, channel_drive_permit_bit_o, bus_oe_o, busy_o});
    $display("reset test done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    #1;
    t_active;
    t_loop;
    t_reset;
    print_verdict;
  end
  initial begin
    #20000;
    err_total++;
    print_verdict;
  end
endmodule // bus_channel_enable_loopback_bench
bind bus_channel_enable_loopback bel_props u_props (.*);
